//--- verilog/proxy_consts.vh
// constants for the configuration / io proxy register block
`ifndef PROXY_CONSTS_VH
`define PROXY_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_PROXY_DATA 12'h000
`define OFS_PROXY_ADDRESS 12'h004
`define OFS_PROXY_COMMAND 12'h008
`define OFS_MASTER_SETTINGS 12'h00c
`define OFS_BUS_STATUS 12'h010

// ----------------------------------------------------------------------
// proxy command fields
// ----------------------------------------------------------------------
`define CMD_READY_BIT 31
`define CMD_BE_HI 7
`define CMD_BE_LO 4
`define CMD_TYPE_BIT 2
`define CMD_DIR_BIT 0
`define CMD_WRITE_MASK 32'h000000f5

// ----------------------------------------------------------------------
// master settings fields
// ----------------------------------------------------------------------
`define MS_CFG_FLUSH_BIT 10
`define MS_IO_FLUSH_BIT 9
`define MS_MEM_FLUSH_BIT 8
`define MS_RD_MULT_BIT 2
`define MS_RD_LINE_BIT 1
`define MS_WR_INV_BIT 0
`define MS_WRITE_MASK 32'h00000707
`define MS_RESET 32'h00000007

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define ADDR_RESET 32'h00000000
`define CMD_RESET 32'h80000000
`define BUS_TIMEOUT_NS 100000
`define CLK_PERIOD_NS 100
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

//--- verilog/proxy_bus_seq.v
// sequencer that runs one proxied transaction on the bus side
`include "proxy_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module proxy_bus_seq #(
  parameter TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire flush,
  input wire is_read,
  input wire bus_done,
  input wire [31:0] bus_rdata,
  output reg bus_req,
  output reg capture,
  output reg [31:0] captured,
  output reg finished,
  output reg timed_out
);

  localparam S_IDLE = 3'b001;
  localparam S_BUSY = 3'b010;
  localparam S_DONE = 3'b100;

  reg [2:0] state_reg;
  reg [31:0] wait_reg;

  // ----------------------------------------------------------------------
  // request, wait for the bus, capture read data, then report finish
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      wait_reg <= 32'h00000000;
      bus_req <= 1'b0;
      capture <= 1'b0;
      captured <= 32'h00000000;
      finished <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      capture <= 1'b0;
      finished <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          timed_out <= 1'b0;
          if (start) begin
            state_reg <= S_BUSY;
            bus_req <= 1'b1;
            wait_reg <= 32'h00000000;
          end
        end
        S_BUSY: begin
          wait_reg <= wait_reg + 32'h00000001;
          // a flushed or stuck transaction still ends, so ready can return
          if (flush || bus_done || wait_reg >= TIMEOUT_CYC - 1) begin
            bus_req <= 1'b0;
            timed_out <= !bus_done && !flush;
            if (bus_done && is_read) begin
              captured <= bus_rdata;
              capture <= 1'b1;
            end
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          // read data is already captured when finish is signalled
          finished <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- verilog/pci_config_io_proxy.v
// register block that launches single configuration or io bus transactions
// What this block does
// - address word is 32-bit read/write, resets zero, gives bus address.
// - configuration accesses ignore the two lowest address bits.
// - writing the command register starts the transaction with held settings.
// - command bit 31 is read-only ready, reset one, one means accepting.
// - command bits 7..4 are read/write byte enables, reset zero.
// - command bit 2 selects configuration (0) or io (1).
// - command bit 0 selects write (0) or read (1).
// - settings: flush bits 10..8 reset 0, enables 2..0 reset 1.
// - with mastering off, flush bits discard config, io, memory work.
// - burst commands used only when their enable bit is set.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`include "proxy_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module pci_config_io_proxy #(
  parameter TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bus_master_enable,
  input wire bus_done,
  input wire [31:0] bus_rdata,
  input wire mem_pending,
  output reg bus_req,
  output reg [31:0] bus_addr,
  output reg [31:0] bus_wdata,
  output reg [3:0] bus_byte_en,
  output reg bus_is_io,
  output reg bus_is_read,
  output reg mem_flush,
  output reg allow_read_multiple,
  output reg allow_read_line,
  output reg allow_write_invalidate
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [31:0] proxy_data_reg;
  reg [31:0] proxy_address_reg;
  reg [31:0] proxy_command_reg;
  reg [31:0] master_settings_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg start_reg;
  reg last_timeout_reg;
  reg [31:0] rdata_next;
  reg ok_next;
  wire seq_req;
  wire seq_capture;
  wire [31:0] seq_captured;
  wire seq_finished;
  wire seq_timed_out;
  wire mastering_sync;
  reg master_meta_reg;
  reg master_sync_reg;
  wire ready;
  wire do_write;
  wire flush_now;
  wire [31:0] settings_wdata;

  assign ready = proxy_command_reg[`CMD_READY_BIT];
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign mastering_sync = master_sync_reg;
  // reserved settings bits never store, so they read back as zero
  assign settings_wdata = wdata_reg & `MS_WRITE_MASK;

  // ----------------------------------------------------------------------
  // mastering enable comes from another domain, two flops before use
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      master_meta_reg <= 1'b0;
      master_sync_reg <= 1'b0;
    end else begin
      master_meta_reg <= bus_master_enable;
      master_sync_reg <= master_meta_reg;
    end
  end

  // flush applies to the kind of transaction in flight
  assign flush_now = !mastering_sync && (bus_is_io ?
    master_settings_reg[`MS_IO_FLUSH_BIT] : master_settings_reg[`MS_CFG_FLUSH_BIT]);

  // ----------------------------------------------------------------------
  // write channel: address and data accepted in either order
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_reg)
          `OFS_PROXY_DATA, `OFS_PROXY_ADDRESS, `OFS_PROXY_COMMAND,
          `OFS_MASTER_SETTINGS, `OFS_BUS_STATUS: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register updates; byte strobes honoured per lane, except command, written whole when lane 0 strobes
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin : reg_update
    integer i;
    if (!aresetn) begin
      proxy_data_reg <= 32'h00000000;
      proxy_address_reg <= `ADDR_RESET;
      proxy_command_reg <= `CMD_RESET;
      master_settings_reg <= `MS_RESET;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (do_write) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (wstrb_reg[i]) begin
            case (awaddr_reg)
              `OFS_PROXY_DATA: proxy_data_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
              `OFS_PROXY_ADDRESS: proxy_address_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
              `OFS_MASTER_SETTINGS: master_settings_reg[i*8 +: 8] <=
                settings_wdata[i*8 +: 8];
              default: ;
            endcase
          end
        end
        // a command written while busy is dropped; software polls first
        if (awaddr_reg == `OFS_PROXY_COMMAND && ready && wstrb_reg[0]) begin
          proxy_command_reg <= wdata_reg & `CMD_WRITE_MASK;
          start_reg <= 1'b1;
        end
      end
      if (start_reg)
        proxy_command_reg[`CMD_READY_BIT] <= 1'b0;
      else if (seq_finished)
        proxy_command_reg[`CMD_READY_BIT] <= 1'b1;
      if (seq_capture)
        proxy_data_reg <= seq_captured;
    end
  end

  // ----------------------------------------------------------------------
  // launch: settings latched toward the bus when the command lands
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_addr <= 32'h00000000;
      bus_wdata <= 32'h00000000;
      bus_byte_en <= 4'h0;
      bus_is_io <= 1'b0;
      bus_is_read <= 1'b0;
      bus_req <= 1'b0;
      last_timeout_reg <= 1'b0;
    end else begin
      // drop the request on the done edge, so the target sees one answer
      bus_req <= seq_req && !flush_now && !bus_done;
      if (start_reg) begin
        bus_is_io <= proxy_command_reg[`CMD_TYPE_BIT];
        bus_is_read <= proxy_command_reg[`CMD_DIR_BIT];
        bus_byte_en <= proxy_command_reg[`CMD_BE_HI:`CMD_BE_LO];
        bus_wdata <= proxy_data_reg;
        // io keeps low bits as software set them to match byte enables
        bus_addr <= proxy_command_reg[`CMD_TYPE_BIT] ? proxy_address_reg :
          {proxy_address_reg[31:2], 2'b00};
      end
      if (seq_finished)
        last_timeout_reg <= seq_timed_out;
    end
  end

  // ----------------------------------------------------------------------
  // memory master side controls
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_flush <= 1'b0;
      allow_read_multiple <= 1'b1;
      allow_read_line <= 1'b1;
      allow_write_invalidate <= 1'b1;
    end else begin
      mem_flush <= !mastering_sync && mem_pending &&
        master_settings_reg[`MS_MEM_FLUSH_BIT];
      allow_read_multiple <= master_settings_reg[`MS_RD_MULT_BIT];
      allow_read_line <= master_settings_reg[`MS_RD_LINE_BIT];
      allow_write_invalidate <= master_settings_reg[`MS_WR_INV_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    ok_next = 1'b1;
    case (s_axi_araddr)
      `OFS_PROXY_DATA: rdata_next = proxy_data_reg;
      `OFS_PROXY_ADDRESS: rdata_next = proxy_address_reg;
      `OFS_PROXY_COMMAND: rdata_next = proxy_command_reg;
      `OFS_MASTER_SETTINGS: rdata_next = master_settings_reg;
      `OFS_BUS_STATUS: rdata_next = {29'h00000000, last_timeout_reg, mastering_sync, bus_req};
      default: ok_next = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // read channel: one read at a time, answer one cycle after address
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= ok_next ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------------
  proxy_bus_seq #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_reg),
    .flush(flush_now),
    .is_read(bus_is_read),
    .bus_done(bus_done),
    .bus_rdata(bus_rdata),
    .bus_req(seq_req),
    .capture(seq_capture),
    .captured(seq_captured),
    .finished(seq_finished),
    .timed_out(seq_timed_out)
  );

endmodule

`default_nettype wire

//--- verif/proxy_target_model.sv
// far-side bus target model for proxied transactions
`timescale 1ns/100ps
`default_nettype none
module proxy_target_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] lag,
  output logic bus_done,
  output logic [31:0] bus_rdata
);
  logic [3:0] cnt_reg;
  logic fired_reg;
  // ----------
  // one answer per request after lag cycles; lag 4'hf stays silent
  // ----------
  always @(posedge aclk) begin
    bus_done <= 1'h0;
    bus_rdata <= aresetn ? ~bus_rdata : 32'h0; // stale data keeps churning
    if (!aresetn || !bus_req) begin
      cnt_reg <= 4'h0;
      fired_reg <= 1'h0;
    end else if (!fired_reg && lag != 4'hf) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == lag) begin
        bus_done <= 1'h1;
        bus_rdata <= ~bus_addr;
        fired_reg <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/pci_config_io_proxy_assertions.sv
// assertion checker bound to the proxy register block
`timescale 1ns/100ps
`default_nettype none
module proxy_checker #(
  parameter int TIMEOUT_CYC = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic bus_req,
  input wire logic bus_done,
  input wire logic [31:0] bus_addr,
  input wire logic bus_is_io,
  input wire logic mem_pending,
  input wire logic mem_flush
);
  int req_cyc;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the current request, so a hang shows without long repeats
  always @(posedge aclk) begin
    req_cyc <= (!aresetn || !bus_req) ? 0 : req_cyc + 1;
  end
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_no_early_aw: assert property (s_axi_bvalid |-> !(s_axi_awvalid && s_axi_awready))
    else $error("write address taken during response");
  a_req_ends: assert property (bus_req && bus_done |=> !bus_req)
    else $error("request held after done");
  a_cfg_low_bits: assert property (bus_req && !bus_is_io |-> bus_addr[1:0] == 2'h0)
    else $error("config address low bits set");
  a_mem_flush_cause: assert property ($rose(mem_flush) |-> $past(mem_pending))
    else $error("memory flush without pending work");
  a_req_bounded: assert property (req_cyc <= TIMEOUT_CYC + 8)
    else $error("request never finished");
  c_io_done: cover property (bus_req && bus_done && bus_is_io);
  c_mem_flush: cover property ($rose(mem_flush));
  c_read_beat: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pci_config_io_proxy proxy_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .bus_req(bus_req), .bus_done(bus_done), .bus_addr(bus_addr),
  .bus_is_io(bus_is_io), .mem_pending(mem_pending), .mem_flush(mem_flush));
`default_nettype wire

//--- verif/test_pci_config_io_proxy.sv
// self-checking bench for the proxy register block
`timescale 1ns/100ps
`default_nettype none
`include "proxy_consts.vh"
module test_pci_config_io_proxy;
  logic aclk = 1'h0, aresetn = 1'h0, bus_master_enable = 1'h1, mem_pending = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, bus_rdata, bus_addr, bus_wdata, q;
  logic [3:0] s_axi_wstrb = 4'hf, lag = 4'h2, bus_byte_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic bus_done, bus_req, bus_is_io, bus_is_read, mem_flush;
  logic allow_read_multiple, allow_read_line, allow_write_invalidate;
  int error_cnt = 0, n_checks = 0, seed = 20, i, n;
  pci_config_io_proxy #(.TIMEOUT_CYC(64)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bus_master_enable(bus_master_enable), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .mem_pending(mem_pending), .bus_req(bus_req), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_byte_en(bus_byte_en), .bus_is_io(bus_is_io), .bus_is_read(bus_is_read),
    .mem_flush(mem_flush), .allow_read_multiple(allow_read_multiple),
    .allow_read_line(allow_read_line), .allow_write_invalidate(allow_write_invalidate));
  proxy_target_model i_tgt (.aclk(aclk), .aresetn(aresetn), .bus_req(bus_req),
    .bus_addr(bus_addr), .lag(lag), .bus_done(bus_done), .bus_rdata(bus_rdata));
  always #50 aclk = ~aclk;
  // ----------
  // bus tasks and comparison
  // ----------
  task automatic chk(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // one proxied transaction of the given type and direction
  task automatic xact(input logic t, dr);
    logic [31:0] a, d, c, e, r;
    a = $random(seed);
    d = $random(seed);
    r = $random(seed);
    c = {24'h0, t ? 4'h1 << a[1:0] : r[7:4], 1'h0, t, 1'h0, dr};
    e = t ? a : {a[31:2], 2'h0};
    lag <= 4'ha + {2'h0, r[1:0]}; // slow enough to still be busy when polled
    if (!dr) wr(`OFS_PROXY_DATA, d);
    wr(`OFS_PROXY_ADDRESS, a);
    wr(`OFS_PROXY_COMMAND, c);
    while (!bus_req) @(posedge aclk);
    chk(bus_addr, e, "bus addr");
    chk({26'h0, bus_byte_en, bus_is_io, bus_is_read}, {26'h0, c[7:4], t, dr}, "kind");
    chk(dr ? d : bus_wdata, d, "wdata");
    wr(`OFS_PROXY_COMMAND, c ^ 32'h000000f5);
    rd(`OFS_PROXY_COMMAND, r);
    chk(r, c, "busy cmd");
    do rd(`OFS_PROXY_COMMAND, r); while (!r[31]);
    chk(r, c | 32'h80000000, "done cmd");
    if (dr) rd(`OFS_PROXY_DATA, r);
    chk(dr ? r : ~e, ~e, "rdata");
  endtask
  // command that the target never answers; counts polls until ready
  task automatic stall(input logic [31:0] c, output int k);
    logic [31:0] r;
    lag <= 4'hf;
    k = 0;
    wr(`OFS_PROXY_COMMAND, c);
    do begin
      rd(`OFS_PROXY_COMMAND, r);
      k++;
    end while (!r[31]);
    lag <= 4'h2;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`OFS_PROXY_ADDRESS, q);
    chk(q, 32'h0, "addr reset");
    rd(`OFS_PROXY_COMMAND, q);
    chk(q, 32'h80000000, "cmd reset");
    rd(`OFS_MASTER_SETTINGS, q);
    chk(q, 32'h00000007, "settings reset");
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      wr(`OFS_PROXY_ADDRESS, n);
      rd(`OFS_PROXY_ADDRESS, q);
      chk(q, n, "addr rw");
      n = $random(seed);
      wr(`OFS_MASTER_SETTINGS, n);
      rd(`OFS_MASTER_SETTINGS, q);
      chk(q, n & 32'h00000707, "settings rw");
      chk({29'h0, allow_read_multiple, allow_read_line, allow_write_invalidate},
        {29'h0, n[2:0]}, "allow");
    end
    // a single byte lane updates, the others keep their old value
    wr(`OFS_PROXY_ADDRESS, 32'h0);
    s_axi_wstrb <= 4'h2;
    wr(`OFS_PROXY_ADDRESS, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    rd(`OFS_PROXY_ADDRESS, q);
    chk(q, 32'h0000ff00, "addr strobes");
    wr(12'h0f0, 32'hffffffff);
    chk({30'h0, resp}, 32'h2, "unmapped write");
    rd(12'h0f0, q);
    chk({q[31:2], resp}, 32'h2, "unmapped read");
    $display("test registers done");
    for (i = 0; i < 8; i++) xact(i[1], i[0]);
    $display("test transactions done");
    bus_master_enable <= 1'h0;
    mem_pending <= 1'h1;
    wr(`OFS_MASTER_SETTINGS, 32'h00000707);
    repeat (4) @(posedge aclk);
    chk({31'h0, mem_flush}, 32'h1, "mem flush");
    for (i = 0; i < 2; i++) begin
      stall({29'h0, i[0], 2'h0}, n);
      chk({31'h0, n < 5}, 32'h1, "flush");
    end
    rd(`OFS_BUS_STATUS, q);
    chk(q, 32'h00000000, "flush status");
    bus_master_enable <= 1'h1;
    stall(32'h0, n);
    chk({31'h0, n > 8}, 32'h1, "no flush");
    rd(`OFS_BUS_STATUS, q);
    chk(q, 32'h00000006, "timeout status");
    chk({31'h0, mem_flush}, 32'h0, "mem flush off");
    $display("test flush done");
    give_verdict;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (10000) @(posedge aclk);
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
